//--- core/mrxsc_pkg.sv
// Package of register map, field layout and reset values for the receive statistics slice.
package mrxsc_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_COUNTER_CONTROL = 12'h100;
	localparam logic [11:0] ADDR_RESERVED_A      = 12'h10c;
	localparam logic [11:0] ADDR_RESERVED_B      = 12'h110;
	localparam logic [11:0] ADDR_RX_ALL          = 12'h200;
	localparam logic [11:0] ADDR_RX_GOOD         = 12'h204;

	// ----------------------------------------------------------------
	// Counter control fields
	// ----------------------------------------------------------------
	localparam int          MAX_FRAME_LSB        = 3;
	localparam int          MAX_FRAME_MSB        = 13;
	localparam int          MAX_FRAME_WIDTH      = 11;
	localparam int          ENABLE_BIT           = 1;
	localparam logic [10:0] MAX_FRAME_RESET      = 11'h5ee;
	localparam logic [31:0] CONTROL_RESET        = 32'h0000_2f72;
	localparam logic [31:0] CONTROL_WRITE_MASK   = 32'h0000_3fff;
	localparam logic [31:0] RESERVED_RESET       = 32'h0000_0000;
	localparam logic [31:0] COUNT_RESET          = 32'h0000_0000;
	localparam logic [31:0] COUNT_STEP           = 32'h0000_0001;

endpackage

//--- core/mrxsc_counter.sv
// Free-running 32-bit event counter that wraps and clears only on reset.
`timescale 1ns/1ps
module mrxsc_counter
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        event_pulse,
	output logic [31:0]      count
);
	import mrxsc_pkg::*;

	logic [31:0] next_count;

	// Plain modular add: all ones steps back to zero, no saturation.
	always_comb
	begin
		next_count = count;
		if (event_pulse)
		begin
			next_count = count + COUNT_STEP;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= COUNT_RESET;
		end
		else
		begin
			count <= next_count;
		end
	end
endmodule

//--- core/mrxsc_top.sv
// Receive statistics slice: APB registers, frame counters and long-frame flag.
`timescale 1ns/1ps
module mrxsc_top
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_frame_done,
	input  wire logic        rx_frame_valid,
	input  wire logic        tx_frame_done,
	input  wire logic [13:0] tx_frame_length,
	output logic             tx_long_frame
);
	import mrxsc_pkg::*;

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [31:0] counter_control;
	logic [31:0] reserved_control_word_a;
	logic [31:0] reserved_control_word_b;
	logic [31:0] rx_all_frames_count;
	logic [31:0] rx_good_frames_count;
	logic [31:0] next_counter_control;
	logic [31:0] next_reserved_a;
	logic [31:0] next_reserved_b;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        next_tx_long_frame;
	logic [31:0] wmask;
	logic        access;
	logic        write_commit;
	logic        hit_control;
	logic        hit_reserved_a;
	logic        hit_reserved_b;
	logic        hit_rx_all;
	logic        hit_rx_good;
	logic [10:0] max_frame_length;

	assign access = psel && penable && !pready;
	assign write_commit = psel && penable && pready && pwrite;
	assign max_frame_length = counter_control[MAX_FRAME_MSB:MAX_FRAME_LSB];

	// ----------------------------------------------------------------
	// Frame counters
	// ----------------------------------------------------------------
	// Event inputs come from receive logic on pclk, so no synchroniser is needed.
	mrxsc_counter u_rx_all
	(
		.pclk        (pclk),
		.presetn     (presetn),
		.event_pulse (rx_frame_done),
		.count       (rx_all_frames_count)
	);

	mrxsc_counter u_rx_good
	(
		.pclk        (pclk),
		.presetn     (presetn),
		.event_pulse (rx_frame_done && rx_frame_valid),
		.count       (rx_good_frames_count)
	);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	always_comb
	begin
		hit_control = 1'b0;
		hit_reserved_a = 1'b0;
		hit_reserved_b = 1'b0;
		hit_rx_all = 1'b0;
		hit_rx_good = 1'b0;
		if (paddr == ADDR_COUNTER_CONTROL)
		begin
			hit_control = 1'b1;
		end
		else if (paddr == ADDR_RESERVED_A)
		begin
			hit_reserved_a = 1'b1;
		end
		else if (paddr == ADDR_RESERVED_B)
		begin
			hit_reserved_b = 1'b1;
		end
		else if (paddr == ADDR_RX_ALL)
		begin
			hit_rx_all = 1'b1;
		end
		else if (paddr == ADDR_RX_GOOD)
		begin
			hit_rx_good = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// APB response, one wait state per access
	// ----------------------------------------------------------------
	always_comb
	begin
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		if (access)
		begin
			next_pready = 1'b1;
			next_prdata = 32'h0000_0000;
			if (hit_control)
			begin
				if (!pwrite)
				begin
					next_prdata = counter_control;
				end
			end
			else if (hit_reserved_a)
			begin
				if (!pwrite)
				begin
					next_prdata = reserved_control_word_a;
				end
			end
			else if (hit_reserved_b)
			begin
				if (!pwrite)
				begin
					next_prdata = reserved_control_word_b;
				end
			end
			else if (hit_rx_all)
			begin
				// Writes to a counter are refused; reads leave it untouched.
				next_pslverr = pwrite;
				next_prdata = pwrite ? 32'h0000_0000 : rx_all_frames_count;
			end
			else if (hit_rx_good)
			begin
				next_pslverr = pwrite;
				next_prdata = pwrite ? 32'h0000_0000 : rx_good_frames_count;
			end
			else
			begin
				next_pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// A write lands only at the edge where the master sees pready high,
	// so an access that is still waiting never changes a register.
	always_comb
	begin
		wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
		next_counter_control = counter_control;
		next_reserved_a = reserved_control_word_a;
		next_reserved_b = reserved_control_word_b;
		if (write_commit)
		begin
			if (hit_control)
			begin
				next_counter_control = ((counter_control & ~wmask)
					| (pwdata & wmask)) & CONTROL_WRITE_MASK;
			end
			else if (hit_reserved_a)
			begin
				next_reserved_a = (reserved_control_word_a & ~wmask) | (pwdata & wmask);
			end
			else if (hit_reserved_b)
			begin
				next_reserved_b = (reserved_control_word_b & ~wmask) | (pwdata & wmask);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			counter_control <= CONTROL_RESET;
			reserved_control_word_a <= RESERVED_RESET;
			reserved_control_word_b <= RESERVED_RESET;
		end
		else
		begin
			counter_control <= next_counter_control;
			reserved_control_word_a <= next_reserved_a;
			reserved_control_word_b <= next_reserved_b;
		end
	end

	// ----------------------------------------------------------------
	// Long-frame classification
	// ----------------------------------------------------------------
	always_comb
	begin
		next_tx_long_frame = 1'b0;
		if (tx_frame_done && (tx_frame_length > {3'b000, max_frame_length}))
		begin
			next_tx_long_frame = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_long_frame <= 1'b0;
		end
		else
		begin
			tx_long_frame <= next_tx_long_frame;
		end
	end
endmodule

//--- verif/mrxsc_checker.sv
// Port checker of the receive statistics slice.
`timescale 1ns/1ps
module mrxsc_checker
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        tx_frame_done,
	input wire logic [13:0] tx_frame_length,
	input wire logic        tx_long_frame
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("wait");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready long");
	a_ready_phase: assert property (pready |-> psel && penable) else $error("pready stray");
	a_err_pulse: assert property (pslverr |-> pready) else $error("pslverr stray");
	a_count_ro: assert property (pready && pwrite && paddr[11:3] == 9'h040 && !paddr[1] |-> pslverr)
		else $error("counter write taken");
	a_unmapped_read: assert property (pready && !pwrite && paddr == 12'h300 |-> pslverr && prdata == 0)
		else $error("unmapped read");
	a_long_big: assert property (tx_frame_done && tx_frame_length > 14'h7ff |=> tx_long_frame)
		else $error("long missed");
	a_long_cause: assert property (!tx_frame_done |=> !tx_long_frame) else $error("long stray");
endmodule
bind mrxsc_top mrxsc_checker u_chk (.*);

//--- verif/testbench.sv
// Self-checking bench of the receive statistics slice.
`timescale 1ns/1ps
module testbench;
	import mrxsc_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic [3:0]  pstrb = 4'hf;
	logic        pready, pslverr, tx_long_frame;
	logic        rx_frame_done = 0, rx_frame_valid = 0, tx_frame_done = 0;
	logic [13:0] tx_frame_length = 0;
	int          n_mismatch = 0, checks = 0;
	mrxsc_top uut (.*);
	initial forever #50 pclk = ~pclk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		chk(pready, 1, "pready");
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] r;
		logic        e;
		apb(0, a, 0, r, e);
		chk(r, exp, nm);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic e);
		logic [31:0] r;
		apb(1, a, d, r, e);
	endtask
	task automatic tx(input logic [13:0] len, input logic exp);
		@(posedge pclk);
		tx_frame_done <= 1;
		tx_frame_length <= len;
		@(posedge pclk);
		tx_frame_done <= 0;
		#1 chk(tx_long_frame, exp, "long");
	endtask
	task automatic t_reset();
		rd(ADDR_COUNTER_CONTROL, {18'h0, 11'b10111101110, 3'b010}, "ctrl");
		rd(ADDR_RX_ALL, 0, "all");
		rd(ADDR_RX_GOOD, 0, "good");
		rd(12'h300, 0, "hole");
		tx(14'h5ee, 0);
		tx(14'h5ef, 1);
		$display("test reset done");
	endtask
	task automatic t_setup();
		logic e;
		wr(ADDR_RESERVED_A, 32'hffffffff, e);
		wr(ADDR_RESERVED_B, 32'hffffffff, e);
		rd(ADDR_RESERVED_A, 32'hffffffff, "resa");
		rd(ADDR_RESERVED_B, 32'hffffffff, "resb");
		pstrb <= 4'h3;
		wr(ADDR_RESERVED_A, 32'h0000_0000, e);
		pstrb <= 4'hf;
		rd(ADDR_RESERVED_A, 32'hffff0000, "lanes");
		wr(ADDR_RESERVED_A, 32'hffffffff, e);
		rd(ADDR_RESERVED_A, 32'hffffffff, "resa");
		wr(ADDR_COUNTER_CONTROL, {18'h0, 11'd100, 3'b010}, e);
		rd(ADDR_COUNTER_CONTROL, {18'h0, 11'd100, 3'b010}, "ctrl");
		tx(14'd100, 0);
		tx(14'd101, 1);
		tx(14'h800, 1);
		$display("test setup done");
	endtask
	task automatic t_count();
		logic        e;
		logic [31:0] start_count;
		logic [31:0] end_count;
		apb(0, ADDR_RX_ALL, 0, start_count, e);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge pclk);
			rx_frame_done <= 1;
			rx_frame_valid <= i != 1;
		end
		@(posedge pclk);
		rx_frame_done <= 0;
		rd(ADDR_RX_ALL, 3, "all");
		rd(ADDR_RX_GOOD, 2, "good");
		apb(0, ADDR_RX_ALL, 0, end_count, e);
		chk(end_count - start_count, 3, "all delta");
		rd(ADDR_RX_ALL, 3, "all");
		wr(ADDR_RX_ALL, 0, e);
		chk(e, 1, "slverr");
		rd(ADDR_RX_ALL, 3, "all");
		@(posedge pclk);
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		rd(ADDR_RX_ALL, 0, "all");
		rd(ADDR_RX_GOOD, 0, "good");
		rd(ADDR_COUNTER_CONTROL, {18'h0, 11'b10111101110, 3'b010}, "ctrl");
		$display("test count done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		t_reset();
		t_setup();
		t_count();
		complete_run();
	end
	initial
	begin
		#1000000;
		n_mismatch++;
		complete_run();
	end
endmodule
